// *** src/port_owner_pkg.sv ***
package port_owner_pkg;

	// ----------------------------------------
	// Owner encoding and configuration codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		upstream_host_one = 2'h0,
		upstream_host_two = 2'h1,
		port_unowned = 2'h2
	} owner_t;

	typedef struct packed {
		owner_t p4;
		owner_t p3;
		owner_t p2;
		owner_t p1;
	} owner_map_t;

	localparam int NUM_PORTS = 4;
	localparam int NUM_CONFIGS = 8;
	localparam logic [2:0] CFG_EMBEDDED = 3'h0;
	localparam logic [2:0] CFG_SMBUS = 3'h1;
	localparam logic [2:0] CFG_LEVEL = 3'h2;
	localparam logic [2:0] CFG_EDGE_SINGLE = 3'h4;
	localparam logic [2:0] CFG_EDGE_DUAL = 3'h5;
	localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2c;
	localparam logic [7:0] DELAY_REG_ADDR = 8'hd0;
	localparam logic [7:0] STATUS_CMD_ADDR = 8'hff;
	localparam logic [7:0] STATUS_CMD_RESET = 8'h00;
	localparam logic [7:0] DELAY_RESET = 8'h00;
	localparam int ATTACH_BIT = 0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int HIGH_PULSE_MIN_NS = 100;
	localparam int HIGH_PULSE_CYC = (HIGH_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DELAY_TICK_DEFAULT = 200;

	// Default embedded configurations, ports four to one
	localparam owner_map_t OWNER_RESET = '{upstream_host_one, upstream_host_one, upstream_host_one,
		upstream_host_one};
	localparam owner_map_t [NUM_CONFIGS-1:0] EMBED_DEFAULTS = '{
		'{port_unowned, upstream_host_one, upstream_host_one, upstream_host_one},
		'{port_unowned, upstream_host_two, upstream_host_one, upstream_host_one},
		'{upstream_host_one, upstream_host_one, upstream_host_one, upstream_host_two},
		'{upstream_host_one, upstream_host_two, upstream_host_two, upstream_host_two},
		'{upstream_host_two, upstream_host_one, upstream_host_one, upstream_host_one},
		'{upstream_host_two, upstream_host_two, upstream_host_one, upstream_host_one},
		'{upstream_host_two, upstream_host_two, upstream_host_two, upstream_host_two},
		'{upstream_host_one, upstream_host_one, upstream_host_one, upstream_host_one}
	};

endpackage : port_owner_pkg

// *** src/hub_port_ownership_select.sv ***
`timescale 1ns/10ps
`default_nettype none

module hub_port_ownership_select #(
	parameter int DELAY_TICK = port_owner_pkg::DELAY_TICK_DEFAULT
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Pins
	input wire logic [3:0] owner_select_pins,
	input wire logic [2:0] cfg_select_pins,
	// Register writes decoded by the SMBus slave
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic cfg_wr,
	input wire logic [2:0] cfg_index,
	input wire port_owner_pkg::owner_map_t cfg_wdata,
	input wire logic smbus_owner_wr,
	input wire port_owner_pkg::owner_map_t smbus_owner_wdata,
	// Results
	output port_owner_pkg::owner_map_t port_owner,
	output logic smbus_slave_en,
	output logic [6:0] smbus_slave_addr,
	output logic attach_command
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [3:0] pin_meta_ff;
	logic [3:0] pin_sync_ff;
	logic [2:0] cfg_meta_ff;
	logic [2:0] cfg_sync_ff;
	logic rel_ff;
	logic [2:0] mode_ff;
	logic [7:0] delay_ff;
	logic [7:0] status_ff;
	port_owner_pkg::owner_map_t [7:0] cfg_table_ff;
	port_owner_pkg::owner_map_t owner_ff;

	// Two flops each; the second is the only reader of the first
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta_ff <= 4'h0;
			pin_sync_ff <= 4'h0;
		end else begin
			pin_meta_ff <= owner_select_pins;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// Strap flops keep running in reset, so the strap is settled at release
	always_ff @(posedge mclk) begin
		cfg_meta_ff <= cfg_select_pins;
		cfg_sync_ff <= cfg_meta_ff;
	end

	// ----------------------------------------
	// Strap capture at reset release
	// ----------------------------------------
	// Caught by a clock edge after release, never by the reset itself
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rel_ff <= 1'b0;
			mode_ff <= 3'h0;
		end else if (!rel_ff) begin
			rel_ff <= 1'b1;
			mode_ff <= cfg_sync_ff;
		end
	end

	wire active = rel_ff;
	wire m_embed = active && (mode_ff == port_owner_pkg::CFG_EMBEDDED);
	wire m_smbus = active && (mode_ff == port_owner_pkg::CFG_SMBUS);
	wire m_level = active && (mode_ff == port_owner_pkg::CFG_LEVEL);
	wire m_edge = active && ((mode_ff == port_owner_pkg::CFG_EDGE_SINGLE) ||
		(mode_ff == port_owner_pkg::CFG_EDGE_DUAL));
	// Edge modes here always support the unowned state
	wire use_unowned = m_edge;

	// ----------------------------------------
	// Registers written over SMBus
	// ----------------------------------------
	// Configuration table reloadable over SMBus
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_table_ff <= port_owner_pkg::EMBED_DEFAULTS;
			delay_ff <= port_owner_pkg::DELAY_RESET;
			status_ff <= port_owner_pkg::STATUS_CMD_RESET;
		end else begin
			if (cfg_wr)
				cfg_table_ff[cfg_index] <= cfg_wdata;
			if (reg_wr && reg_addr == port_owner_pkg::DELAY_REG_ADDR)
				delay_ff <= reg_wdata;
			if (reg_wr && reg_addr == port_owner_pkg::STATUS_CMD_ADDR)
				status_ff <= reg_wdata;
		end
	end

	assign smbus_slave_en = m_smbus;
	assign smbus_slave_addr = port_owner_pkg::SMBUS_SLAVE_ADDR;
	assign attach_command = status_ff[port_owner_pkg::ATTACH_BIT];

	// ----------------------------------------
	// Delay tick divider
	// ----------------------------------------
	// One delay unit per tick; the unit scale is a parameter
	logic [15:0] div_ff;
	wire tick = (div_ff == 16'(DELAY_TICK - 1));
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			div_ff <= 16'h0000;
		else
			div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
	end

	// ----------------------------------------
	// Embedded and level target with switching delay
	// ----------------------------------------
	port_owner_pkg::owner_map_t level_map;
	port_owner_pkg::owner_map_t target_map;
	port_owner_pkg::owner_map_t pend_ff;
	logic [7:0] hold_ff;
	always_comb begin
		level_map.p1 = pin_sync_ff[0] ? port_owner_pkg::upstream_host_two : port_owner_pkg::upstream_host_one;
		level_map.p2 = pin_sync_ff[1] ? port_owner_pkg::upstream_host_two : port_owner_pkg::upstream_host_one;
		level_map.p3 = pin_sync_ff[2] ? port_owner_pkg::upstream_host_two : port_owner_pkg::upstream_host_one;
		level_map.p4 = pin_sync_ff[3] ? port_owner_pkg::upstream_host_two : port_owner_pkg::upstream_host_one;
	end
	// Fourth pin never reaches the table index
	assign target_map = m_embed ? cfg_table_ff[pin_sync_ff[2:0]] : level_map;
	wire settled = (target_map == pend_ff) && (hold_ff >= delay_ff);

	// Target must stay stable for the whole delay, which filters bouncing switches
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pend_ff <= port_owner_pkg::OWNER_RESET;
			hold_ff <= 8'h00;
		end else if (target_map != pend_ff) begin
			pend_ff <= target_map;
			hold_ff <= 8'h00;
		end else if (tick && hold_ff != 8'hff) begin
			hold_ff <= hold_ff + 8'h01;
		end
	end

	// ----------------------------------------
	// Edge filter per pin
	// ----------------------------------------
	logic [3:0] edge_hit;
	logic [1:0] edge_owner [4];
	genvar gi;
	generate
		for (gi = 0; gi < port_owner_pkg::NUM_PORTS; gi++) begin : g_edge
			logic [7:0] hi_cnt_ff;
			logic [7:0] lo_cnt_ff;
			logic armed_ff;
			logic taken_ff;
			logic [1:0] own_ff;
			wire hi_ok = (hi_cnt_ff == 8'(port_owner_pkg::HIGH_PULSE_CYC - 1)) && pin_sync_ff[gi];
			wire lo_ok = (lo_cnt_ff >= delay_ff) && tick && !pin_sync_ff[gi];
			wire [1:0] own_nxt = (own_ff == 2'(port_owner_pkg::upstream_host_one)) ?
				2'(port_owner_pkg::upstream_host_two) :
				((own_ff == 2'(port_owner_pkg::upstream_host_two) && use_unowned) ?
				2'(port_owner_pkg::port_unowned) : 2'(port_owner_pkg::upstream_host_one));
			assign edge_hit[gi] = m_edge && armed_ff && !taken_ff && hi_ok;
			assign edge_owner[gi] = own_ff;
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					hi_cnt_ff <= 8'h00;
					lo_cnt_ff <= 8'h00;
					armed_ff <= 1'b1;
					taken_ff <= 1'b0;
					own_ff <= 2'(port_owner_pkg::upstream_host_one);
				end else begin
					hi_cnt_ff <= pin_sync_ff[gi] ? ((hi_ok) ? hi_cnt_ff : hi_cnt_ff + 8'h01) : 8'h00;
					if (pin_sync_ff[gi])
						lo_cnt_ff <= 8'h00;
					else if (tick && lo_cnt_ff != 8'hff)
						lo_cnt_ff <= lo_cnt_ff + 8'h01;
					if (!pin_sync_ff[gi])
						taken_ff <= 1'b0;
					if (edge_hit[gi]) begin
						own_ff <= own_nxt;
						armed_ff <= 1'b0;
						taken_ff <= 1'b1;
					end else if (lo_ok) begin
						armed_ff <= 1'b1;
					end
				end
			end
		end
	endgenerate

	port_owner_pkg::owner_map_t edge_map;
	assign edge_map = '{port_owner_pkg::owner_t'(edge_owner[3]), port_owner_pkg::owner_t'(edge_owner[2]),
		port_owner_pkg::owner_t'(edge_owner[1]), port_owner_pkg::owner_t'(edge_owner[0])};

	// ----------------------------------------
	// Owner register
	// ----------------------------------------
	// Only the mode captured at release may touch the owners
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			owner_ff <= port_owner_pkg::OWNER_RESET;
		else if ((m_embed || m_level) && settled)
			owner_ff <= pend_ff;
		else if (m_edge)
			owner_ff <= edge_map;
		else if (m_smbus && smbus_owner_wr && attach_command)
			owner_ff <= smbus_owner_wdata;
	end
	assign port_owner = owner_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_reset_owner: assert property (@(posedge mclk) disable iff (!rst_b)
		!rel_ff |=> owner_ff == port_owner_pkg::OWNER_RESET) else $error("owner moved before release");
	chk_edge_start: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(rel_ff) |-> edge_owner[0] == 2'(port_owner_pkg::upstream_host_one))
		else $error("edge owner not host one");
	chk_smbus_gate: assert property (@(posedge mclk) disable iff (!rst_b)
		(m_smbus && !attach_command) |=> $stable(owner_ff)) else $error("owner changed without attach");
	chk_smbus_addr: assert property (@(posedge mclk) disable iff (!rst_b)
		smbus_slave_en |-> smbus_slave_addr == 7'h2c) else $error("bad slave address");
	chk_short_high: assert property (@(posedge mclk) disable iff (!rst_b)
		edge_hit[1] |-> $past(pin_sync_ff[1], 19)) else $error("edge on short pulse");
	chk_edge_lock: assert property (@(posedge mclk) disable iff (!rst_b)
		edge_hit[1] |=> !edge_hit[1]) else $error("edge accepted twice");
	chk_edge_cycle: assert property (@(posedge mclk) disable iff (!rst_b)
		(edge_hit[1] && edge_owner[1] == 2'h0) |=> edge_owner[1] == 2'h1) else $error("bad cycle step");
	chk_level_delay: assert property (@(posedge mclk) disable iff (!rst_b)
		(m_level && target_map != pend_ff) |=> $stable(owner_ff)) else $error("level change without delay");

endmodule : hub_port_ownership_select

`default_nettype wire

// *** tb/owner_switch_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----
// Switch or GPIO model on the select pins
// ----
module owner_switch_model (
	// Clock
	input wire logic mclk,
	// Pins
	output logic [3:0] pins
);
	// Idle low from time zero
	initial pins = 4'h0;

	// Level change 1 ns after an edge
	task automatic set_pins(input logic [3:0] v);
		@(posedge mclk);
		#1 pins = v;
	endtask : set_pins

	// High hi cycles, low lo cycles; hi below 20 breaks the minimum on purpose
	task automatic pulse(input int n, input int hi, input int lo);
		@(posedge mclk);
		#1 pins[n] = 1'b1;
		repeat (hi) @(posedge mclk);
		#1 pins[n] = 1'b0;
		repeat (lo) @(posedge mclk);
	endtask : pulse
endmodule : owner_switch_model

`default_nettype wire

// *** tb/tb_hub_port_ownership_select.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_hub_port_ownership_select;
	// ----
	// Signals
	// ----
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] pins;
	logic [2:0] strap = 3'h0;
	logic reg_wr = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic cfg_wr = 1'b0;
	logic [2:0] cfg_index = 3'h0;
	port_owner_pkg::owner_map_t cfg_wdata = 8'h00;
	logic own_wr = 1'b0;
	port_owner_pkg::owner_map_t own_wdata = 8'h00;
	port_owner_pkg::owner_map_t port_owner, last_map;
	logic slave_en, attach;
	logic [6:0] slave_addr;
	port_owner_pkg::owner_map_t exp_q[$];
	int num_errors = 0;
	int n_compared = 0;
	int k, j;
	logic [3:0] v, pv;
	logic [7:0] rd;
	// Owner maps per code: 0 host one, 1 host two, 2 unowned
	logic [7:0] emb [8] = '{8'h00, 8'h55, 8'h50, 8'h40, 8'h15, 8'h01, 8'h90, 8'h80};

	// 200 MHz
	always #2.5 mclk = ~mclk;

	owner_switch_model sw (.mclk(mclk), .pins(pins));

	// Short delay unit keeps the run brief
	hub_port_ownership_select #(.DELAY_TICK(4)) dut (
		.mclk(mclk), .rst_b(rst_b), .owner_select_pins(pins), .cfg_select_pins(strap),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .cfg_wr(cfg_wr),
		.cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .smbus_owner_wr(own_wr),
		.smbus_owner_wdata(own_wdata), .port_owner(port_owner), .smbus_slave_en(slave_en),
		.smbus_slave_addr(slave_addr), .attach_command(attach));

	// ----
	// Compare and report
	// ----
	task automatic check_map(input string w, input port_owner_pkg::owner_map_t e,
		input port_owner_pkg::owner_map_t s);
		n_compared++;
		if (e !== s) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", w, e, s);
		end
	endtask : check_map

	task automatic check_sig(input string w, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (e !== s) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", w, e, s);
		end
	endtask : check_sig

	task automatic print_verdict();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	// Bounded wait for all notes to be consumed
	task automatic wait_done();
		for (int i = 0; i < 600 && exp_q.size() > 0; i++)
			@(posedge mclk);
		if (exp_q.size() > 0) begin
			num_errors++;
			print_verdict();
		end
	endtask : wait_done

	// ----
	// Drivers
	// ----
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge mclk);
		#1 reg_wr = 1'b0;
	endtask : reg_write

	task automatic cfg_load(input logic [2:0] i, input logic [7:0] d);
		@(posedge mclk);
		#1 cfg_wr = 1'b1;
		cfg_index = i;
		cfg_wdata = d;
		@(posedge mclk);
		#1 cfg_wr = 1'b0;
	endtask : cfg_load

	task automatic owner_write(input logic [7:0] d);
		@(posedge mclk);
		#1 own_wr = 1'b1;
		own_wdata = d;
		@(posedge mclk);
		#1 own_wr = 1'b0;
	endtask : owner_write

	// Pins wiggle in reset, then settle low before release
	task automatic do_reset(input logic [2:0] s);
		@(posedge mclk);
		#1 rst_b = 1'b0;
		strap = s;
		sw.set_pins(4'($urandom));
		repeat (8) @(posedge mclk);
		check_map("owner in reset", 8'h00, port_owner);
		sw.set_pins(4'h0);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge mclk);
	endtask : do_reset

	// Level pins to owner map, one bit per port
	function automatic logic [7:0] lvl(input logic [3:0] p);
		return {1'b0, p[3], 1'b0, p[2], 1'b0, p[1], 1'b0, p[0]};
	endfunction : lvl

	// Each owner change takes the oldest note; a change with none noted is wrong
	always @(negedge mclk) begin
		if (rst_b === 1'b1 && port_owner !== last_map) begin
			if (exp_q.size() == 0)
				check_map("unexpected owner", last_map, port_owner);
			else
				check_map("owner", exp_q.pop_front(), port_owner);
		end
		last_map = port_owner;
	end

	// ----
	// Tests
	// ----
	initial begin
		void'($urandom(66653));
		do_reset(3'h0);
		check_sig("slave enable", 8'h00, {7'h00, slave_en});
		reg_write(8'hd0, 8'h04);
		for (k = 1; k <= 8; k++) begin
			exp_q.push_back(emb[k % 8]);
			sw.set_pins({1'($urandom), 3'(k % 8)});
			repeat (6) @(posedge mclk);
			check_map("owner before delay", emb[k - 1], port_owner);
			wait_done();
		end
		rd = {2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 3), 2'h1};
		cfg_load(3'h3, rd);
		exp_q.push_back(rd);
		sw.set_pins(4'h3);
		wait_done();
		$display("test embedded done");
		// Level mode, random pins, each differing from the last
		do_reset(3'h2);
		reg_write(8'hd0, 8'h01);
		pv = 4'h0;
		for (k = 0; k < 8; k++) begin
			v = 4'($urandom);
			if (v == pv)
				v = ~v;
			exp_q.push_back(lvl(v));
			sw.set_pins(v);
			wait_done();
			pv = v;
		end
		$display("test level done");
		// Edge mode, both straps
		for (j = 4; j < 6; j++) begin
			do_reset(3'(j));
			check_map("owner at start", 8'h00, port_owner);
			reg_write(8'hd0, 8'h04);
			for (k = 1; k <= 3; k++) begin
				exp_q.push_back(8'((k % 3) << 2));
				sw.pulse(1, 25, 30);
				wait_done();
			end
			// Short pulse must not count, nor a pulse after a short low
			sw.pulse(1, 15, 30);
			exp_q.push_back(8'h04);
			sw.pulse(1, 25, 2);
			sw.pulse(1, 25, 30);
			wait_done();
		end
		$display("test edge done");
		do_reset(3'h1);
		check_sig("slave enable", 8'h01, {7'h00, slave_en});
		check_sig("slave address", 8'h2c, {1'b0, slave_addr});
		rd = {2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 3), 2'h1};
		owner_write(rd);
		repeat (3) @(posedge mclk);
		check_map("refused write", 8'h00, port_owner);
		check_sig("attach", 8'h00, {7'h00, attach});
		reg_write(8'hff, 8'h01);
		check_sig("attach", 8'h01, {7'h00, attach});
		exp_q.push_back(rd);
		owner_write(rd);
		wait_done();
		$display("test smbus done");
		print_verdict();
	end
endmodule : tb_hub_port_ownership_select

`default_nettype wire
